// File: include/qdu_pkg.sv
// Package for the quad channel update control block.
// Assumes a single 10 MHz clock domain; all pin inputs are synchronised by the user of it.
package qdu_pkg;

  // Channel and word geometry.
  localparam int CHAN_COUNT = 4;
  localparam int WORD_WIDTH = 12;
  localparam int CODE_WIDTH = 10;
  localparam int BYTE_WIDTH = 8;
  localparam int SEL_WIDTH  = 2;

  // Control byte field positions.
  localparam int CTL_EXT_HI_POS   = 7;
  localparam int CTL_EXT_LO_POS   = 6;
  localparam int CTL_MODE_HI_POS  = 5;
  localparam int CTL_MODE_LO_POS  = 4;
  localparam int CTL_PICK_HI_POS  = 2;
  localparam int CTL_PICK_LO_POS  = 1;
  localparam int CTL_PDFLAG_POS   = 0;

  // High byte power-down field and low byte code field positions.
  localparam int HI_PWR_HI_POS    = 7;
  localparam int HI_PWR_LO_POS    = 6;
  localparam int LO_CODE_HI_POS   = 7;
  localparam int LO_CODE_LO_POS   = 6;

  // Update mode encodings.
  localparam logic [1:0] MODE_STORE     = 2'h0;
  localparam logic [1:0] MODE_LOAD_ONE  = 2'h1;
  localparam logic [1:0] MODE_LOAD_ALL  = 2'h2;
  localparam logic [1:0] MODE_BROADCAST = 2'h3;

  // Reset values.
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [7:0]  BYTE_RESET = 8'h00;
  localparam logic [11:0] WORD_RESET = 12'h000;
  localparam logic [9:0]  CODE_ZERO  = 10'h000;
  localparam logic [1:0]  PWR_NORMAL = 2'h0;

  // Synchroniser depth for pin inputs.
  localparam int SYNC_STAGES = 2;

  // Byte sequencer phases.
  typedef enum logic [1:0] {
    QDU_PH_CTRL = 2'b00,
    QDU_PH_HIGH = 2'b01,
    QDU_PH_LOW  = 2'b10,
    QDU_PH_DONE = 2'b11
  } qdu_phase_e;

  typedef logic [CHAN_COUNT-1:0][WORD_WIDTH-1:0] qdu_bank_t;

endpackage

// File: src/qdu_sync.sv
// Two flip-flop synchroniser for a group of asynchronous pin levels.
// Assumes the output is read only in the clock_in domain.
`timescale 1ns/1ps
`default_nettype none

module qdu_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  import qdu_pkg::*;

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] hold_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      meta_r <= '0;
      hold_r <= '0;
    end
    else
    begin
      meta_r <= async_in;
      hold_r <= meta_r;
    end
  end

  assign sync_out = hold_r;

endmodule
`default_nettype wire

// File: src/qdu_update_ctrl.sv
// Control byte decoder and channel register bank of a quad 10-bit DAC.
// Assumes a front end delivers each received byte after its eighth bit and
// before the falling edge of the acknowledge clock, and flags stop or restart.
// The link clock, load pin and address pins arrive asynchronously and are
// synchronised here; bytes, frame ends and the readback select come from clock_in logic.
`timescale 1ns/1ps
`default_nettype none

module qdu_update_ctrl (
  input  wire logic                               clock_in,
  input  wire logic                               rst_in,
  input  wire logic                               byte_valid_in,
  input  wire logic [qdu_pkg::BYTE_WIDTH-1:0]     byte_data_in,
  input  wire logic                               frame_end_in,
  input  wire logic                               scl_in,
  input  wire logic                               async_load_pin_in,
  input  wire logic                               ext_addr_hi_in,
  input  wire logic                               ext_addr_lo_in,
  input  wire logic [qdu_pkg::SEL_WIDTH-1:0]      readback_sel_in,
  output logic      [qdu_pkg::WORD_WIDTH-1:0]     output_code_chan_a_out,
  output logic      [qdu_pkg::WORD_WIDTH-1:0]     output_code_chan_b_out,
  output logic      [qdu_pkg::WORD_WIDTH-1:0]     output_code_chan_c_out,
  output logic      [qdu_pkg::WORD_WIDTH-1:0]     output_code_chan_d_out,
  output logic      [qdu_pkg::WORD_WIDTH-1:0]     readback_out,
  output logic                                    update_out
);
  import qdu_pkg::*;

  // All state of the block in one record.
  typedef struct packed {
    qdu_phase_e                phase;
    logic [BYTE_WIDTH-1:0]     control_byte_reg;
    logic [BYTE_WIDTH-1:0]     high_data_byte_reg;
    logic [BYTE_WIDTH-1:0]     low_data_byte_reg;
    logic                      pending;
    // Edge memories for the synchronised link clock and load pin.
    logic                      scl_prev;
    logic                      load_prev;
    // Per-channel staging words and output code words.
    qdu_bank_t                 staging;
    qdu_bank_t                 output_code;
    logic [WORD_WIDTH-1:0]     readback;
    logic                      update;
  } qdu_state_s;

  qdu_state_s state_r;
  qdu_state_s state_nxt;

  // Synchronised pin levels.
  // The raw pins are packed in the order the synchroniser sees them.
  logic [3:0] pins_async;
  logic [3:0] pins_sync;
  logic       scl_s;
  logic       load_s;
  logic       ext_hi_s;
  logic       ext_lo_s;

  // Decoded control fields.
  logic [1:0]            update_mode;
  logic [SEL_WIDTH-1:0]  channel_pick;
  logic                  channel_pick_hi;
  logic                  powerdown_flag;
  logic                  ext_match;
  logic                  broadcast;
  logic [WORD_WIDTH-1:0] new_word;

  // Events.
  logic scl_fall;
  logic load_rise;
  logic apply;

  // Per-channel load decisions.
  // Taking the received word has priority over a reload from staging.
  logic [CHAN_COUNT-1:0] take_staging;
  logic [CHAN_COUNT-1:0] out_from_new;
  logic [CHAN_COUNT-1:0] out_from_staging;

  // Pin inputs cross into the clock domain through two flip-flops.
  // Each bit settles on its own, so two address pins may change in different cycles.
  assign pins_async = {ext_addr_hi_in, ext_addr_lo_in, async_load_pin_in, scl_in};

  qdu_sync #(
    .WIDTH (4)
  ) u_pin_sync (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .async_in (pins_async),
    .sync_out (pins_sync)
  );

  // Bit order follows the concatenation above.
  assign scl_s    = pins_sync[0];
  assign load_s   = pins_sync[1];
  assign ext_lo_s = pins_sync[2];
  assign ext_hi_s = pins_sync[3];

  // Edge detection on the synchronised link clock and load pin.
  // An edge is acted on three clock cycles after it reaches the pin, and a
  // link clock low phase shorter than one clock cycle may be missed.
  assign scl_fall  = state_r.scl_prev & ~scl_s;
  assign load_rise = ~state_r.load_prev & load_s;

  // The latched control byte is split into its fields; bit 3 is never read.
  // Fields come from the latched byte, never straight from the byte port.
  assign update_mode     = {state_r.control_byte_reg[CTL_MODE_HI_POS],
                            state_r.control_byte_reg[CTL_MODE_LO_POS]};
  assign channel_pick    = {state_r.control_byte_reg[CTL_PICK_HI_POS],
                            state_r.control_byte_reg[CTL_PICK_LO_POS]};
  assign channel_pick_hi = state_r.control_byte_reg[CTL_PICK_HI_POS];
  assign powerdown_flag  = state_r.control_byte_reg[CTL_PDFLAG_POS];
  assign broadcast       = (update_mode == MODE_BROADCAST);

  // Address pins must agree with control bits 7:6 except in broadcast.
  // The pins are judged in the cycle in which the low byte arrives.
  assign ext_match = broadcast
                   | ((state_r.control_byte_reg[CTL_EXT_HI_POS] == ext_hi_s)
                   &  (state_r.control_byte_reg[CTL_EXT_LO_POS] == ext_lo_s));

  // Word built from the received bytes: code or power-down command.
  // A power-down word carries a zero code field whatever the master sent.
  always_comb
  begin
    if (powerdown_flag)
    begin
      new_word = {state_r.high_data_byte_reg[HI_PWR_HI_POS],
                  state_r.high_data_byte_reg[HI_PWR_LO_POS], CODE_ZERO};
    end
    else
    begin
      new_word = {PWR_NORMAL, state_r.high_data_byte_reg,
                  state_r.low_data_byte_reg[LO_CODE_HI_POS],
                  state_r.low_data_byte_reg[LO_CODE_LO_POS]};
    end
  end

  // A complete pair is applied on the acknowledge clock's falling edge.
  // The pair waits in pending from the low byte until that fall, so the
  // output never moves before the acknowledge.
  assign apply = state_r.pending & scl_fall;

  // Decide per channel which registers a pending update touches.
  // The pick compare is the only difference between the copies.
  genvar ch;
  generate
    for (ch = 0; ch < CHAN_COUNT; ch++)
    begin : g_chan
      logic picked;
      logic take_stg;
      logic out_new;
      logic out_stg;

      // Each channel compares the pick field with its own index.
      assign picked = (channel_pick == SEL_WIDTH'(ch));

      // One row per update mode: which registers of this channel change.
      always_comb
      begin
        take_stg = 1'b0;
        out_new  = 1'b0;
        out_stg  = 1'b0;
        case (update_mode)
          MODE_STORE:
          begin
            // Staging only, so the channel output holds its value.
            take_stg = picked;
          end
          MODE_LOAD_ONE:
          begin
            take_stg = picked;
            out_new  = picked;
          end
          MODE_LOAD_ALL:
          begin
            // The other channels reload from their old staging words.
            take_stg = picked;
            out_new  = picked;
            out_stg  = ~picked;
          end
          MODE_BROADCAST:
          begin
            // Pick high bit chooses received word or staging; staging is kept.
            out_new = channel_pick_hi;
            out_stg = ~channel_pick_hi;
          end
          default:
          begin
            take_stg = 1'b0;
          end
        endcase
      end

      // Collected into the block-wide decision vectors.
      assign take_staging[ch]     = take_stg;
      assign out_from_new[ch]     = out_new;
      assign out_from_staging[ch] = out_stg;
    end
  endgenerate

  // Next-state logic: byte sequencing, register updates and readback.
  // Later assignments in this process override earlier ones on purpose.
  always_comb
  begin
    // Hold every field except the edge memories, update and readback unless a branch below changes it.
    state_nxt           = state_r;
    state_nxt.scl_prev  = scl_s;
    state_nxt.load_prev = load_s;
    state_nxt.update    = 1'b0;

    // Load pin edge copies every staging register at once.
    // It copies the staging words as they stood before this cycle's serial write.
    if (load_rise)
    begin
      state_nxt.output_code = state_r.staging;
      state_nxt.update      = 1'b1;
    end

    // Serial update applied after the pin copy so written channels win.
    // A channel that takes the received word ignores its staging reload.
    if (apply)
    begin
      state_nxt.pending = 1'b0;
      state_nxt.update  = 1'b1;
      for (int i = 0; i < CHAN_COUNT; i++)
      begin
        if (take_staging[i])
        begin
          state_nxt.staging[i] = new_word;
        end
        if (out_from_new[i])
        begin
          state_nxt.output_code[i] = new_word;
        end
        else if (out_from_staging[i])
        begin
          state_nxt.output_code[i] = state_r.staging[i];
        end
      end
    end

    // Byte sequencer: control byte, then high and low pairs.
    // A stop or repeated start wins over a byte offered in the same cycle.
    if (frame_end_in)
    begin
      state_nxt.phase = QDU_PH_CTRL;
    end
    else if (byte_valid_in)
    begin
      case (state_r.phase)
        QDU_PH_CTRL:
        begin
          // Every frame opens with its control byte.
          state_nxt.control_byte_reg = byte_data_in;
          state_nxt.phase            = QDU_PH_HIGH;
        end
        QDU_PH_HIGH:
        begin
          // The high byte waits here until its low byte completes the pair.
          state_nxt.high_data_byte_reg = byte_data_in;
          state_nxt.phase              = QDU_PH_LOW;
        end
        QDU_PH_LOW:
        begin
          state_nxt.low_data_byte_reg = byte_data_in;
          // Arming here overrides a clear by an apply in the same cycle.
          state_nxt.pending           = ext_match;
          // Power-down commands take exactly two bytes; data pairs repeat.
          state_nxt.phase = powerdown_flag ? QDU_PH_DONE : QDU_PH_HIGH;
        end
        QDU_PH_DONE:
        begin
          // Bytes after the two power-down bytes are dropped until the frame ends.
          state_nxt.phase = QDU_PH_DONE;
        end
        default:
        begin
          // An unused phase code restarts at the control byte.
          state_nxt.phase = QDU_PH_CTRL;
        end
      endcase
    end

    // Readback shows the selected staging register.
    // It reads the next-state copy, so a written word shows in the same cycle as its staging register.
    state_nxt.readback = state_nxt.staging[readback_sel_in];
  end

  // State register; everything clears to zero on reset.
  // Reset is synchronous and clears the synchroniser too; one cycle is enough.
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      state_r.phase              <= QDU_PH_CTRL;
      state_r.control_byte_reg   <= CTRL_RESET;
      state_r.high_data_byte_reg <= BYTE_RESET;
      state_r.low_data_byte_reg  <= BYTE_RESET;
      state_r.pending            <= 1'b0;
      // Edge memories start at the synchroniser's reset level: no false edge.
      state_r.scl_prev           <= 1'b0;
      state_r.load_prev          <= 1'b0;
      state_r.staging            <= '0;
      state_r.output_code        <= '0;
      state_r.readback           <= WORD_RESET;
      state_r.update             <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Outputs come straight from the state register.
  // No decode sits between the state register and the pins.
  assign output_code_chan_a_out = state_r.output_code[0];
  assign output_code_chan_b_out = state_r.output_code[1];
  assign output_code_chan_c_out = state_r.output_code[2];
  assign output_code_chan_d_out = state_r.output_code[3];
  assign readback_out           = state_r.readback;
  assign update_out             = state_r.update;

endmodule
`default_nettype wire

// File: testbench/qdu_chk_assertions.sv
// Checker for qdu_update_ctrl: reset state, update pulse and its causes.
// Assumes it is bound to qdu_update_ctrl and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module qdu_chk (
  input wire logic                           clock_in,
  input wire logic                           rst_in,
  input wire logic                           scl_in,
  input wire logic                           async_load_pin_in,
  input wire logic [qdu_pkg::SEL_WIDTH-1:0]  readback_sel_in,
  input wire logic [qdu_pkg::WORD_WIDTH-1:0] output_code_chan_a_out,
  input wire logic [qdu_pkg::WORD_WIDTH-1:0] output_code_chan_b_out,
  input wire logic [qdu_pkg::WORD_WIDTH-1:0] output_code_chan_c_out,
  input wire logic [qdu_pkg::WORD_WIDTH-1:0] output_code_chan_d_out,
  input wire logic [qdu_pkg::WORD_WIDTH-1:0] readback_out,
  input wire logic                           update_out
);
  import qdu_pkg::*;
  qdu_bank_t  outs;
  logic       pd_ok;
  logic       scl_prev_r;
  logic       pin_prev_r;
  logic [3:0] since_r;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  // Gathers the four channel words.
  assign outs = {output_code_chan_d_out, output_code_chan_c_out,
                 output_code_chan_b_out, output_code_chan_a_out};

  // A power-down word must carry a zero code field.
  always_comb
  begin
    pd_ok = 1'b1;
    for (int i = 0; i < CHAN_COUNT; i++)
      if (outs[i][11:10] != PWR_NORMAL && outs[i][9:0] != CODE_ZERO)
        pd_ok = 1'b0;
  end

  // Counts cycles since the last link clock fall or load pin rise.
  always_ff @(posedge clock_in)
  begin
    scl_prev_r <= scl_in;
    pin_prev_r <= async_load_pin_in;
    if (rst_in || (scl_prev_r && !scl_in) || (!pin_prev_r && async_load_pin_in))
      since_r <= 4'h0;
    else if (since_r != 4'hF)
      since_r <= since_r + 4'h1;
  end

  chk_reset_clear: assert property
    ($fell(rst_in) |-> outs == '0 && readback_out == '0 && !update_out)
    else $error("Outputs not clear after reset");
  chk_update_single: assert property (update_out |=> !update_out)
    else $error("Update pulse longer than one cycle");
  chk_change_cause: assert property ($changed(outs) |-> update_out)
    else $error("Output code changed without update");
  chk_update_bound: assert property (update_out |-> since_r <= 4'h5)
    else $error("Update without a recent link fall or load pin rise");
  chk_pin_update: assert property ($rose(async_load_pin_in) |-> ##[2:4] update_out)
    else $error("Load pin rise gave no update");
  chk_pd_word_out: assert property (pd_ok)
    else $error("Power-down output word has a code field");
  chk_pd_word_rb: assert property
    (readback_out[11:10] == PWR_NORMAL || readback_out[9:0] == CODE_ZERO)
    else $error("Power-down staging word has a code field");
  chk_idle_stable: assert property
    (since_r == 4'hF && $past(readback_sel_in) == $past(readback_sel_in, 2)
     |-> $stable(readback_out))
    else $error("Staging word changed while the link was idle");
endmodule

bind qdu_update_ctrl qdu_chk qdu_chk_i (
  .clock_in               (clock_in),
  .rst_in                 (rst_in),
  .scl_in                 (scl_in),
  .async_load_pin_in      (async_load_pin_in),
  .readback_sel_in        (readback_sel_in),
  .output_code_chan_a_out (output_code_chan_a_out),
  .output_code_chan_b_out (output_code_chan_b_out),
  .output_code_chan_c_out (output_code_chan_c_out),
  .output_code_chan_d_out (output_code_chan_d_out),
  .readback_out           (readback_out),
  .update_out             (update_out)
);
`default_nettype wire

// File: testbench/qdu_master_model.sv
// Serial master stand-in: hands bytes to the byte port and clocks the link.
// Assumes a 100 ns clock_in; the link clock runs, at a period of 1200 ns or more, only within frames.
`timescale 1ns/1ps
`default_nettype none
module qdu_master_model (
  input  wire logic       clock_in,
  output logic            byte_valid_out,
  output logic [7:0]      byte_data_out,
  output logic            frame_end_out,
  output logic            scl_out
);
  // Idle: link clock parked high, no byte offered.
  initial
  begin
    byte_valid_out = 1'b0;
    byte_data_out  = 8'hA5;
    frame_end_out  = 1'b0;
    scl_out        = 1'b1;
  end

  // One byte, then its acknowledge clock; slow delays the falling edge.
  task automatic put(input logic [7:0] b, input int slow);
    @(posedge clock_in);
    byte_valid_out <= 1'b1;
    byte_data_out  <= b;
    @(posedge clock_in);
    byte_valid_out <= 1'b0;
    byte_data_out  <= ~b;
    repeat (2 + slow) @(posedge clock_in);
    scl_out <= 1'b0;
    repeat (4) @(posedge clock_in);
    scl_out <= 1'b1;
    repeat (4) @(posedge clock_in);
  endtask

  // Control byte, then one high and low pair, then stop.
  task automatic frame(input logic [7:0] c, h, l, input int slow);
    put(c, 0);
    put(h, 0);
    put(l, slow);
    stop();
  endtask

  // Stop or repeated start: one cycle of frame end.
  task automatic stop();
    @(posedge clock_in);
    frame_end_out <= 1'b1;
    @(posedge clock_in);
    frame_end_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// Testbench: sends frames through the master model and checks all channels.
// Assumes the master model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import qdu_pkg::*;
  logic             clock_in = 1'b0;
  logic             rst_in = 1'b1;
  logic             pin = 1'b0;
  logic             ext_hi = 1'b1;
  logic             ext_lo = 1'b0;
  logic [1:0]       rb_sel = 2'h0;
  wire logic        valid, fend, scl, update;
  wire logic [7:0]  data;
  wire logic [11:0] rb;
  wire qdu_bank_t   outs;
  qdu_bank_t        stg_m = '0;
  qdu_bank_t        out_m = '0;
  int               errors = 0;
  int               samples_checked = 0;

  qdu_master_model qdu_master_model_i (
    .clock_in       (clock_in),
    .byte_valid_out (valid),
    .byte_data_out  (data),
    .frame_end_out  (fend),
    .scl_out        (scl)
  );
  qdu_update_ctrl qdu_update_ctrl_i (
    .clock_in               (clock_in),
    .rst_in                 (rst_in),
    .byte_valid_in          (valid),
    .byte_data_in           (data),
    .frame_end_in           (fend),
    .scl_in                 (scl),
    .async_load_pin_in      (pin),
    .ext_addr_hi_in         (ext_hi),
    .ext_addr_lo_in         (ext_lo),
    .readback_sel_in        (rb_sel),
    .output_code_chan_a_out (outs[0]),
    .output_code_chan_b_out (outs[1]),
    .output_code_chan_c_out (outs[2]),
    .output_code_chan_d_out (outs[3]),
    .readback_out           (rb),
    .update_out             (update)
  );

  // Clock at 10 MHz.
  always #50 clock_in = ~clock_in;

  task automatic finish_test();
    $display("Compared %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Reads back every staging word and compares every output code.
  task automatic chk_all();
    for (int i = 0; i < CHAN_COUNT; i++)
    begin
      @(posedge clock_in);
      rb_sel <= i[1:0];
      repeat (2) @(posedge clock_in);
      #1;
      cmp(rb, stg_m[i]);
      cmp(outs[i], out_m[i]);
    end
  endtask

  // Sends one frame and applies its expected effect to the model.
  task automatic wr(input logic [7:0] c, input logic [7:0] h, input logic [7:0] l);
    logic [11:0] w;
    logic [1:0]  s;
    logic        ok;
    w  = c[0] ? {h[7:6], CODE_ZERO} : {PWR_NORMAL, h, l[7:6]};
    s  = c[2:1];
    ok = c[7:6] == {ext_hi, ext_lo};
    qdu_master_model_i.frame(c, h, l, 6);
    case (c[5:4])
      MODE_STORE: if (ok) stg_m[s] = w;
      MODE_LOAD_ONE: if (ok) {stg_m[s], out_m[s]} = {w, w};
      MODE_LOAD_ALL:
        if (ok)
        begin
          stg_m[s] = w;
          out_m    = stg_m;
        end
      default: out_m = c[2] ? {4{w}} : stg_m;
    endcase
  endtask

  task automatic sc_store();
    for (int s = 0; s < CHAN_COUNT; s++)
      wr({5'h11, s[1:0], 1'b0}, {6'h24, s[1:0]}, 8'hFF);
    wr(8'h83, 8'hC0, 8'h00);
    chk_all();
  endtask

  task automatic sc_load_one();
    fork
      wr(8'h94, 8'hA5, 8'h80);
      begin
        repeat (33) @(posedge clock_in);
        #1;
        cmp(outs[2], out_m[2]);
      end
    join
    chk_all();
  endtask

  task automatic sc_load_all();
    wr(8'hA2, 8'h3C, 8'h40);
    wr(8'hA7, 8'h80, 8'h00);
    wr(8'h50, 8'hFF, 8'hC0);
    chk_all();
  endtask

  task automatic sc_bcast();
    wr(8'h88, 8'h5A, 8'hC0);
    wr(8'h30, 8'hFF, 8'hFF);
    chk_all();
    wr(8'h34, 8'h96, 8'h40);
    chk_all();
    wr(8'h35, 8'h80, 8'h00);
    chk_all();
  endtask

  task automatic sc_pin();
    wr(8'h8A, 8'h12, 8'h40);
    @(posedge clock_in);
    pin <= 1'b1;
    repeat (6) @(posedge clock_in);
    pin <= 1'b0;
    out_m = stg_m;
    chk_all();
  endtask

  // Two pairs in one frame, then power-down bytes beyond the two expected.
  task automatic sc_pairs();
    qdu_master_model_i.put(8'h90, 0);
    qdu_master_model_i.put(8'h11, 0);
    qdu_master_model_i.put(8'h40, 6);
    #1;
    cmp(outs[0], {PWR_NORMAL, 8'h11, 2'h1});
    qdu_master_model_i.put(8'hEE, 0);
    qdu_master_model_i.put(8'hC0, 6);
    qdu_master_model_i.stop();
    {stg_m[0], out_m[0]} = {2{PWR_NORMAL, 8'hEE, 2'h3}};
    qdu_master_model_i.put(8'h93, 0);
    qdu_master_model_i.put(8'h40, 0);
    qdu_master_model_i.put(8'h00, 6);
    qdu_master_model_i.put(8'hFF, 0);
    qdu_master_model_i.put(8'hFF, 6);
    qdu_master_model_i.stop();
    {stg_m[1], out_m[1]} = {2{2'h1, CODE_ZERO}};
    chk_all();
  endtask

  // Reset in mid-run clears every word; a frame follows at once.
  task automatic sc_reset();
    @(posedge clock_in);
    rst_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    rst_in <= 1'b0;
    stg_m = '0;
    out_m = '0;
    #1;
    cmp(rb, WORD_RESET);
    cmp(outs[3], WORD_RESET);
    wr(8'h98, 8'h5A, 8'h80);
    chk_all();
  endtask

  // Address pins moved: the new match is taken, the old one refused.
  task automatic sc_ext();
    @(posedge clock_in);
    ext_hi <= 1'b0;
    ext_lo <= 1'b1;
    @(posedge clock_in);
    wr(8'h50, 8'h33, 8'h80);
    wr(8'h9C, 8'h77, 8'h00);
    chk_all();
  endtask

  // Main sequence.
  initial
  begin
    repeat (10) @(posedge clock_in);
    rst_in <= 1'b0;
    repeat (20) @(posedge clock_in);
    chk_all();
    sc_store();
    sc_load_one();
    sc_load_all();
    sc_bcast();
    sc_pin();
    sc_pairs();
    sc_reset();
    sc_ext();
    finish_test();
  end

  // Cuts a hang short.
  initial
  begin
    repeat (20000) @(posedge clock_in);
    errors++;
    finish_test();
  end
endmodule
`default_nettype wire
